// ==== logic/ioc_map.svh ====
// Register offsets, field positions, reset values and limits of the block
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// Register byte offsets
`define IOC_CTRL_OFS        8'h00
`define IOC_START_OFS       8'h04
`define IOC_STATUS_OFS      8'h08

// Control register fields
`define IOC_CTRL_OP_LSB     0
`define IOC_CTRL_OP_MSB     1

// Status register fields
`define IOC_STAT_TRIP_LSB   0
`define IOC_STAT_TRIP_MSB   2
`define IOC_STAT_GEN_BIT    3
`define IOC_STAT_BLK_BIT    4
`define IOC_STAT_DBL_BIT    5

// Operation mode codes
`define IOC_OP_OFF_CODE     2'h0
`define IOC_OP_PEAK_CODE    2'h1
`define IOC_OP_FUND_CODE    2'h2

// Start current setting, percent of rated current
`define IOC_START_MIN       12'h014
`define IOC_START_MAX       12'hBB8
`define IOC_START_RST       12'h0C8

// Peak selection window, samples
`define IOC_PEAK_WINDOW     16'h0010

`endif

// ==== logic/ioc_pkg.sv ====
// Types and decode helpers shared by the overcurrent block
package ioc_pkg;
  `include "ioc_map.svh"

  // Operation setting of the function
  typedef enum logic [1:0] {
    OP_OFF,
    OP_PEAK,
    OP_FUND
  } op_mode_t;

  // Raw register code to mode; unknown codes fall back to off
  function automatic op_mode_t decode_mode(input logic [1:0] code);
    case (code)
      `IOC_OP_PEAK_CODE: decode_mode = OP_PEAK;
      `IOC_OP_FUND_CODE: decode_mode = OP_FUND;
      default:           decode_mode = OP_OFF;
    endcase
  endfunction

  // A start setting is legal only inside its range
  function automatic logic start_legal(input logic [11:0] value);
    start_legal = (value >= `IOC_START_MIN) && (value <= `IOC_START_MAX);
  endfunction
endpackage

// ==== logic/peak_select.sv ====
// Per-phase peak selection from signed current samples
`timescale 1ns/10ps
module peak_select #(
  parameter int          DATA_W = 16,
  parameter logic [15:0] WINDOW = 16'h0010
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Sample stream
  input  wire logic              i_sample_valid,
  input  wire logic [DATA_W-1:0] i_sample,
  // Selected peak magnitude
  output logic      [DATA_W-1:0] o_peak
);
  logic [DATA_W-1:0] mag;
  logic [DATA_W-1:0] run_r;
  logic [DATA_W-1:0] prev_r;
  logic [15:0]       cnt_r;
  logic [DATA_W-1:0] run_nxt;

  // Magnitude of two's complement sample, most negative saturates
  always_comb begin
    if (i_sample[DATA_W-1]) begin
      mag = (i_sample == {1'b1, {(DATA_W-1){1'b0}}}) ?
            {1'b0, {(DATA_W-1){1'b1}}} : DATA_W'(-i_sample);
    end else begin
      mag = i_sample;
    end
    run_nxt = (mag > run_r) ? mag : run_r;
  end

  // Window counter; old peaks age out so the trip can drop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 16'h0000;
    end else if (i_sample_valid) begin
      cnt_r <= (cnt_r >= WINDOW - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end

  // Running maximum of this window and held maximum of the last
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_r  <= '0;
      prev_r <= '0;
    end else if (i_sample_valid) begin
      if (cnt_r >= WINDOW - 16'h0001) begin
        prev_r <= run_nxt;
        run_r  <= '0;
      end else begin
        run_r  <= run_nxt;
      end
    end
  end

  // Peak includes the newest sample so a step is seen at once
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_peak <= '0;
    end else if (i_sample_valid) begin
      o_peak <= (run_nxt > prev_r) ? run_nxt : prev_r;
    end
  end
endmodule // peak_select

// ==== logic/phase_compare.sv ====
// Per-phase instantaneous comparison of a value with the threshold
`timescale 1ns/10ps
module phase_compare #(
  parameter int DATA_W = 16
) (
  // Selected measured value and active threshold
  input  wire logic [DATA_W-1:0] i_value,
  input  wire logic [12:0]       i_threshold,
  // Overall enable
  input  wire logic              i_enable,
  // Comparison result
  output logic                   o_above
);
  // Strictly above; zero-extend the narrower side first. Chosen at
  // elaboration so the unused branch never holds a negative replication
  generate
    if (DATA_W >= 13) begin : g_wide
      always_comb begin
        o_above = i_enable &&
                  ({{(DATA_W+1-13){1'b0}}, i_threshold} <
                   {1'b0, i_value});
      end
    end else begin : g_narrow
      always_comb begin
        o_above = i_enable &&
                  (i_threshold < {{(13-DATA_W){1'b0}}, i_value});
      end
    end
  endgenerate
endmodule // phase_compare

// ==== logic/three_phase_instant_overcurrent.sv ====
// Three-phase instantaneous overcurrent decision with register port
//
// Function
// R1 - Phase value above threshold trips at once
// R2 - Operation off, peak or fundamental; default off
// R3 - Start setting 20 to 3000 percent, default 200
// R4 - Trip after inherent latency only, no delay
// R5 - Double input doubles threshold for all phases
// R6 - Block input suppresses every trip output
// R7 - General trip is OR of phase trips
// R8 - Peak value selected per phase separately
// R9 - Upstream supplies fundamental RMS per phase
// R10 - One trip output per phase, independent
// R11 - Disabled mode holds all trips low
// R12 - Trip drops when value falls, no latch
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "ioc_map.svh"
module three_phase_instant_overcurrent
  import ioc_pkg::*;
#(
  parameter int          DATA_W      = 16,
  parameter logic [15:0] PEAK_WINDOW = `IOC_PEAK_WINDOW
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  // Sampled phase currents, signed
  input  wire logic              i_sample_valid,
  input  wire logic [DATA_W-1:0] i_phase1_current_sample,
  input  wire logic [DATA_W-1:0] i_phase2_current_sample,
  input  wire logic [DATA_W-1:0] i_phase3_current_sample,
  // Fundamental RMS values from the upstream stage
  input  wire logic [DATA_W-1:0] i_phase1_fundamental_rms,
  input  wire logic [DATA_W-1:0] i_phase2_fundamental_rms,
  input  wire logic [DATA_W-1:0] i_phase3_fundamental_rms,
  // User logic status inputs
  input  wire logic              i_function_block_input,
  input  wire logic              i_setting_double_input,
  // Selected peaks for observation
  output logic      [DATA_W-1:0] o_phase1_peak_value,
  output logic      [DATA_W-1:0] o_phase2_peak_value,
  output logic      [DATA_W-1:0] o_phase3_peak_value,
  // Trip outputs
  output logic                   o_phase1_trip_out,
  output logic                   o_phase2_trip_out,
  output logic                   o_phase3_trip_out,
  output logic                   o_general_trip_out
);
  import ioc_pkg::*;

  logic [1:0]        op_code_r;
  logic [11:0]       start_r;
  op_mode_t          mode;
  logic [12:0]       threshold;
  logic              enable;
  logic [2:0]        above;
  logic [2:0]        trip_r;
  logic [DATA_W-1:0] samples [3];
  logic [DATA_W-1:0] funds   [3];
  logic [DATA_W-1:0] peaks   [3];
  logic [DATA_W-1:0] sel     [3];
  logic [1:0]        wr_code;
  logic [11:0]       wr_start;

  assign samples[0] = i_phase1_current_sample;
  assign samples[1] = i_phase2_current_sample;
  assign samples[2] = i_phase3_current_sample;
  // R9 upstream RMS values
  assign funds[0]   = i_phase1_fundamental_rms;
  assign funds[1]   = i_phase2_fundamental_rms;
  assign funds[2]   = i_phase3_fundamental_rms;

  assign wr_code  = i_wdata[`IOC_CTRL_OP_MSB:`IOC_CTRL_OP_LSB];
  assign wr_start = i_wdata[11:0];

  // Operation setting; unknown codes are refused, old value kept
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // R2 default off
      op_code_r <= `IOC_OP_OFF_CODE;
    end else if (i_wr && (i_addr == `IOC_CTRL_OFS) &&
                 (wr_code != 2'h3)) begin
      op_code_r <= wr_code;
    end
  end

  // Start setting; out of range writes are ignored, not clamped,
  // so a bad write never silently moves the threshold
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // R3 default and range
      start_r <= `IOC_START_RST;
    end else if (i_wr && (i_addr == `IOC_START_OFS) &&
                 start_legal(wr_start) && (i_wdata[31:12] == 20'h00000)) begin
      start_r <= wr_start;
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `IOC_CTRL_OFS:   o_rdata <= {30'h0, op_code_r};
        `IOC_START_OFS:  o_rdata <= {20'h00000, start_r};
        `IOC_STATUS_OFS: o_rdata <= {26'h0,
                                     i_setting_double_input,
                                     i_function_block_input,
                                     o_general_trip_out, trip_r};
        default:         o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  assign mode = decode_mode(op_code_r);

  // Threshold and enable for all phases
  always_comb begin
    // R5 doubled threshold
    threshold = i_setting_double_input ? {start_r, 1'b0} : {1'b0, start_r};
    // R6 block and R11 off mode
    enable    = !i_function_block_input && (mode != OP_OFF);
  end

  // One peak selector and comparator per phase
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      // R8 per-phase peak
      peak_select #(
        .DATA_W (DATA_W),
        .WINDOW (PEAK_WINDOW)
      ) u_peak (
        .i_clk          (i_clk),
        .i_reset_n      (i_reset_n),
        .i_sample_valid (i_sample_valid),
        .i_sample       (samples[g]),
        .o_peak         (peaks[g])
      );

      // R2 mode selects quantity
      assign sel[g] = (mode == OP_PEAK) ? peaks[g] : funds[g];

      // R1 compare with setting
      phase_compare #(
        .DATA_W (DATA_W)
      ) u_cmp (
        .i_value     (sel[g]),
        .i_threshold (threshold),
        .i_enable    (enable),
        .o_above     (above[g])
      );
    end
  endgenerate

  // Trips follow the comparison each cycle, one register of latency
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trip_r <= 3'h0;
    end else begin
      // R4 R10 R12 unlatched per phase
      trip_r <= above;
    end
  end

  // General trip registered beside the phase trips
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_general_trip_out <= 1'b0;
    end else begin
      // R7 any phase trip
      o_general_trip_out <= |above;
    end
  end

  assign o_phase1_trip_out   = trip_r[0];
  assign o_phase2_trip_out   = trip_r[1];
  assign o_phase3_trip_out   = trip_r[2];
  assign o_phase1_peak_value = peaks[0];
  assign o_phase2_peak_value = peaks[1];
  assign o_phase3_peak_value = peaks[2];
endmodule // three_phase_instant_overcurrent

// ==== tb/ioc_props.sv ====
// Assertion checker bound to the overcurrent decision block
`timescale 1ns/10ps
module ioc_props #(
  parameter int DATA_W = 16
) (
  // Clock, reset and register port
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic [7:0]        i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  // Measured values and user inputs
  input wire logic              i_sample_valid,
  input wire logic [DATA_W-1:0] i_phase1_current_sample,
  input wire logic [DATA_W-1:0] i_phase1_fundamental_rms,
  input wire logic [DATA_W-1:0] i_phase2_fundamental_rms,
  input wire logic [DATA_W-1:0] i_phase3_fundamental_rms,
  input wire logic              i_function_block_input,
  input wire logic              i_setting_double_input,
  // Peaks and trips
  input wire logic [DATA_W-1:0] o_phase1_peak_value,
  input wire logic [DATA_W-1:0] o_phase2_peak_value,
  input wire logic [DATA_W-1:0] o_phase3_peak_value,
  input wire logic              o_phase1_trip_out,
  input wire logic              o_phase2_trip_out,
  input wire logic              o_phase3_trip_out,
  input wire logic              o_general_trip_out
);
  logic [1:0]  mode_r;
  logic [11:0] start_r;
  logic [12:0] thr;
  logic [2:0]  trips, fund_hi, peak_hi;
  // shadow settings; illegal writes leave them unchanged
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r  <= 2'h0;
      start_r <= 12'h0C8;
    end else if (i_wr && i_addr == 8'h00 && i_wdata[1:0] != 2'h3) begin
      mode_r <= i_wdata[1:0];
    end else if (i_wr && i_addr == 8'h04 && i_wdata >= 32'h14 &&
                 i_wdata <= 32'hBB8) begin
      start_r <= i_wdata[11:0];
    end
  end
  // threshold doubles while the input is high
  assign thr = i_setting_double_input ? {start_r, 1'b0} : {1'b0, start_r};
  assign trips = {o_phase3_trip_out, o_phase2_trip_out, o_phase1_trip_out};
  assign fund_hi = {i_phase3_fundamental_rms > thr,
                    i_phase2_fundamental_rms > thr,
                    i_phase1_fundamental_rms > thr};
  assign peak_hi = {o_phase3_peak_value > thr, o_phase2_peak_value > thr,
                    o_phase1_peak_value > thr};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_gen; o_general_trip_out == |trips; endproperty
  a_gen: assert property (p_gen) else $error("general trip wrong");
  property p_blk; i_function_block_input |=> trips == 3'h0; endproperty
  a_blk: assert property (p_blk) else $error("trip while blocked");
  property p_off; mode_r == 2'h0 |=> trips == 3'h0; endproperty
  a_off: assert property (p_off) else $error("trip while off");
  property p_fund;
    mode_r == 2'h2 && !i_function_block_input |=> trips == $past(fund_hi);
  endproperty
  a_fund: assert property (p_fund) else $error("rms trip wrong");
  property p_peak;
    mode_r == 2'h1 && !i_function_block_input |=> trips == $past(peak_hi);
  endproperty
  a_peak: assert property (p_peak) else $error("peak trip wrong");
  property p_mag;
    i_sample_valid && !i_phase1_current_sample[DATA_W-1] |=>
      o_phase1_peak_value >= $past(i_phase1_current_sample);
  endproperty
  a_mag: assert property (p_mag) else $error("peak below sample");
  property p_rds;
    i_rd && i_addr == 8'h04 |=> o_rdata == {20'h0, $past(start_r)};
  endproperty
  a_rds: assert property (p_rds) else $error("start readback");
  property p_rdm;
    i_rd && i_addr == 8'h00 |=> o_rdata == {30'h0, $past(mode_r)};
  endproperty
  a_rdm: assert property (p_rdm) else $error("mode readback");
  property p_rdt;
    i_rd && i_addr == 8'h08 |=>
      o_rdata[3:0] == {$past(o_general_trip_out), $past(trips)};
  endproperty
  a_rdt: assert property (p_rdt) else $error("status readback");
  property p_rdz; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
  c_gen: cover property (o_general_trip_out);
  c_dbl: cover property (i_setting_double_input && o_phase3_trip_out);
  c_pk: cover property (mode_r == 2'h1 && o_phase2_trip_out);
endmodule // ioc_props

bind three_phase_instant_overcurrent ioc_props #(.DATA_W(DATA_W)) u_props (.*);

// ==== tb/ioc_upstream.sv ====
// Model of the upstream sampling and fundamental stage
`timescale 1ns/10ps
module ioc_upstream (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Amplitudes commanded by the bench
  input  wire logic [2:0][15:0] i_peak,
  input  wire logic [2:0][15:0] i_rms,
  // Stream towards the block
  output logic                  o_valid,
  output logic      [2:0][15:0] o_sample,
  output logic      [2:0][15:0] o_rms
);
  logic sign_r;
  // Square wave, a sample every other cycle; garbage between samples
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_valid  <= 1'b0;
      sign_r   <= 1'b0;
      o_sample <= '0;
    end else begin
      o_valid <= !o_valid;
      if (!o_valid) begin
        sign_r <= !sign_r;
        for (int i = 0; i < 3; i++)
          o_sample[i] <= sign_r ? -i_peak[i] : i_peak[i];
      end else begin
        o_sample <= ~o_sample;
      end
    end
  end
  assign o_rms = i_rms;
endmodule // ioc_upstream

// ==== tb/three_phase_instant_overcurrent_tb.sv ====
// Self-checking bench for the overcurrent decision block
`timescale 1ns/10ps
module three_phase_instant_overcurrent_tb;
  logic        i_clk, i_reset_n, i_wr, i_rd, i_sample_valid;
  logic        i_function_block_input, i_setting_double_input;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] i_phase1_current_sample, i_phase2_current_sample;
  logic [15:0] i_phase3_current_sample, i_phase1_fundamental_rms;
  logic [15:0] i_phase2_fundamental_rms, i_phase3_fundamental_rms;
  logic [15:0] o_phase1_peak_value, o_phase2_peak_value;
  logic [15:0] o_phase3_peak_value;
  logic        o_phase1_trip_out, o_phase2_trip_out;
  logic        o_phase3_trip_out, o_general_trip_out;
  logic [3:0]  trv;
  logic [2:0][15:0] pk, rms, smp, fund;
  logic [31:0] st[6] = '{32'h13, 32'hBB9, 32'h14, 32'hBB8, 32'h10C8, 32'hC8};
  logic [31:0] rb[6] = '{32'hC8, 32'hC8, 32'h14, 32'hBB8, 32'hBB8, 32'hC8};
  logic [31:0] md[4] = '{32'h1, 32'h3, 32'h2, 32'h0};
  logic [31:0] mr[4] = '{32'h1, 32'h1, 32'h2, 32'h0};
  int          n_errors, comparisons;
  // Upstream stage and the block under test
  ioc_upstream upstream (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_peak(pk),
    .i_rms(rms), .o_valid(i_sample_valid), .o_sample(smp), .o_rms(fund));
  assign {i_phase3_current_sample, i_phase2_current_sample,
          i_phase1_current_sample} = smp;
  assign {i_phase3_fundamental_rms, i_phase2_fundamental_rms,
          i_phase1_fundamental_rms} = fund;
  assign trv = {o_general_trip_out, o_phase3_trip_out, o_phase2_trip_out,
                o_phase1_trip_out};
  three_phase_instant_overcurrent #(.PEAK_WINDOW(16'h0004)) uut (.*);
  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Trip outputs: bounded wait, then compare; a hang ends the run
  task automatic wt(input logic [3:0] exp);
    for (int i = 0; i < 40 && trv !== exp; i++) begin
      @(posedge i_clk);
      #1;
    end
    chk({28'h0, trv}, {28'h0, exp});
    if (trv !== exp) complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // Main sequence
  initial begin
    n_errors = 0;
    comparisons = 0;
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    {i_wr, i_rd, i_function_block_input, i_setting_double_input} = 4'h0;
    pk = {3{16'h01F4}};
    rms = {3{16'h01F4}};
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hC8);
    wt(4'h0);
    foreach (st[i]) begin
      wr(8'h04, st[i]);
      rd(8'h04, rb[i]);
    end
    foreach (md[i]) begin
      wr(8'h00, md[i]);
      rd(8'h00, mr[i]);
    end
    wr(8'h00, 32'h2);
    rms <= {16'h0, 16'h00C8, 16'h00C9};
    wt(4'h9);
    rd(8'h08, 32'h9);
    rms <= {16'h0, 16'h00C8, 16'h00C8};
    wt(4'h0);
    i_setting_double_input <= 1'b1;
    rms <= {16'h0191, 16'h0190, 16'h0};
    wt(4'hC);
    i_function_block_input <= 1'b1;
    wt(4'h0);
    rd(8'h08, 32'h30);
    i_function_block_input <= 1'b0;
    wt(4'hC);
    i_setting_double_input <= 1'b0;
    rms <= '0;
    pk <= {16'h0, 16'h012C, 16'h0};
    wr(8'h00, 32'h1);
    wt(4'hA);
    pk <= '0;
    wt(4'h0);
    pk <= {16'h0, 16'h012C, 16'h0};
    wt(4'hA);
    chk({16'h0, o_phase2_peak_value}, 32'h12C);
    chk({o_phase3_peak_value, o_phase1_peak_value}, 32'h0);
    pk <= {16'h8000, 16'h012C, 16'h0};
    wt(4'hE);
    chk({16'h0, o_phase3_peak_value}, 32'h7FFF);
    wr(8'h00, 32'h0);
    wt(4'h0);
    rd(8'h0C, 32'h0);
    // Second reset in mid-run must restore both defaults
    wr(8'h04, 32'h14);
    wr(8'h00, 32'h2);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hC8);
    complete_run();
  end
endmodule // three_phase_instant_overcurrent_tb
